// ==== core/tccv_pkg.sv ====
package tccv_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int VAL_W = 16;
  localparam int NUM_CH = 3;
  // Register byte offsets
  localparam logic [7:0] CH1_OFF = 8'h38;
  localparam logic [7:0] CH2_OFF = 8'h3c;
  localparam logic [7:0] CH3_OFF = 8'h40;
  localparam logic [7:0] STAT_OFF = 8'h80;
  // Reset values
  localparam logic [15:0] VAL_RST = 16'h0000;
  localparam logic [2:0] FLAG_RST = 3'h0;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  // Status field positions
  localparam int STAT_MATCH_LSB = 0;
  localparam int STAT_OVCAP_LSB = 4;
  typedef enum logic {
    TCCV_MODE_OUT = 1'b0,
    TCCV_MODE_IN = 1'b1
  } tccv_mode_e;
endpackage

// ==== core/tccv_chan_if.sv ====
`timescale 1ns/10ps
interface tccv_chan_if;
  logic wr_val;
  logic [15:0] wr_data;
  logic rd_val;
  logic [15:0] value;
  logic [15:0] active;
  logic match_pulse;
  logic overcap_pulse;
  modport top (output wr_val, output wr_data, output rd_val, input value, input active, input match_pulse,
    input overcap_pulse);
  modport chan (input wr_val, input wr_data, input rd_val, output value, output active, output match_pulse,
    output overcap_pulse);
endinterface

// ==== core/tccv_chan.sv ====
`timescale 1ns/10ps
module tccv_chan (
  input wire logic ref_clk, // Timer clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic [15:0] counter_val, // Running counter
  input wire logic capture_evt, // Capture event, one cycle
  input wire logic update_evt, // Update event, one cycle
  input wire logic mode_in, // 1: input mode, 0: output mode
  input wire logic shadow_en, // Shadow buffering enable
  tccv_chan_if.chan bus // Register side
);
  logic [15:0] value_reg;
  logic [15:0] value_next;
  logic [15:0] active_reg;
  logic [15:0] counter_reg;
  logic pending_reg;
  logic match_reg;
  logic overcap_reg;

  always_comb
  begin
    value_next = value_reg;
    if (mode_in == tccv_pkg::TCCV_MODE_IN && capture_evt)
      value_next = counter_val;
    else if (mode_in == tccv_pkg::TCCV_MODE_OUT && bus.wr_val)
      value_next = bus.wr_data;
  end

  // Software field; writes in input mode are ignored and leave it unchanged
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      value_reg <= tccv_pkg::VAL_RST;
    else
      value_reg <= value_next;
  end

  // Compare value in use: at once without shadow, on update with it
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      active_reg <= tccv_pkg::VAL_RST;
    else if (mode_in == tccv_pkg::TCCV_MODE_OUT && (!shadow_en || update_evt))
      active_reg <= value_next;
  end

  // Unread capture tracking; a new capture beats a read in the same cycle
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      pending_reg <= 1'b0;
      overcap_reg <= 1'b0;
    end
    else
    begin
      overcap_reg <= mode_in && capture_evt && pending_reg && !bus.rd_val;
      if (mode_in && capture_evt)
        pending_reg <= 1'b1;
      else if (bus.rd_val)
        pending_reg <= 1'b0;
    end
  end

  // One pulse when the counter arrives at the compare value
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      counter_reg <= tccv_pkg::VAL_RST;
      match_reg <= 1'b0;
    end
    else
    begin
      counter_reg <= counter_val;
      match_reg <= !mode_in && counter_val == active_reg && counter_val != counter_reg;
    end
  end

  assign bus.value = value_reg;
  assign bus.active = active_reg;
  assign bus.match_pulse = match_reg;
  assign bus.overcap_pulse = overcap_reg;
endmodule // tccv_chan

// ==== core/tccv_top.sv ====
// The implementer's own choice: the strobed register port.
`timescale 1ns/10ps
module tccv_top (
  input wire logic ref_clk, // Timer clock, 100 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic [7:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, cycle after strobe
  input wire logic [15:0] counter_val, // Running counter value
  input wire logic [2:0] capture_evt, // Capture event per channel
  input wire logic update_evt, // Update event
  input wire logic [2:0] chan_input_mode, // Per channel: 1 input, 0 output
  input wire logic [2:0] shadow_en, // Per channel shadow enable
  output logic [2:0] compare_match, // Compare match pulse per channel
  output logic [15:0] chan_one_match_value, // Active compare value, channel 1
  output logic [15:0] chan_two_match_value, // Active compare value, channel 2
  output logic [15:0] chan_three_match_value // Active compare value, channel 3
);
  logic [2:0] sel_ch;
  logic sel_stat;
  logic [2:0] match_flag_reg;
  logic [2:0] match_flag_next;
  logic [2:0] ovcap_flag_reg;
  logic [2:0] ovcap_flag_next;
  logic [2:0] match_evt;
  logic [2:0] ovcap_evt;
  logic [2:0] clr_match;
  logic [2:0] clr_ovcap;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [15:0] chan_value [3];
  logic [15:0] chan_active [3];

  tccv_chan_if chan_bus [3] ();

  // Address decode
  always_comb
  begin
    sel_ch[0] = reg_addr == tccv_pkg::CH1_OFF;
    sel_ch[1] = reg_addr == tccv_pkg::CH2_OFF;
    sel_ch[2] = reg_addr == tccv_pkg::CH3_OFF;
    sel_stat = reg_addr == tccv_pkg::STAT_OFF;
  end

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++)
    begin : g_ch
      assign chan_bus[gi].wr_val = reg_wr && sel_ch[gi];
      assign chan_bus[gi].wr_data = reg_wdata[15:0];
      assign chan_bus[gi].rd_val = reg_rd && sel_ch[gi];
      assign chan_value[gi] = chan_bus[gi].value;
      assign chan_active[gi] = chan_bus[gi].active;
      assign match_evt[gi] = chan_bus[gi].match_pulse;
      assign ovcap_evt[gi] = chan_bus[gi].overcap_pulse;

      tccv_chan u_chan (
        .ref_clk(ref_clk),
        .rst(rst),
        .counter_val(counter_val),
        .capture_evt(capture_evt[gi]),
        .update_evt(update_evt),
        .mode_in(chan_input_mode[gi]),
        .shadow_en(shadow_en[gi]),
        .bus(chan_bus[gi])
      );
    end
  endgenerate

  // Write one to clear; a new event in the same cycle keeps the flag set
  always_comb
  begin
    clr_match = (reg_wr && sel_stat) ? reg_wdata[tccv_pkg::STAT_MATCH_LSB +: 3] : 3'h0;
    clr_ovcap = (reg_wr && sel_stat) ? reg_wdata[tccv_pkg::STAT_OVCAP_LSB +: 3] : 3'h0;
    match_flag_next = (match_flag_reg & ~clr_match) | match_evt;
    ovcap_flag_next = (ovcap_flag_reg & ~clr_ovcap) | ovcap_evt;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      match_flag_reg <= tccv_pkg::FLAG_RST;
      ovcap_flag_reg <= tccv_pkg::FLAG_RST;
    end
    else
    begin
      match_flag_reg <= match_flag_next;
      ovcap_flag_reg <= ovcap_flag_next;
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb
  begin
    rdata_next = tccv_pkg::RDATA_RST;
    if (sel_ch[0])
      rdata_next = {16'h0000, chan_value[0]};
    else if (sel_ch[1])
      rdata_next = {16'h0000, chan_value[1]};
    else if (sel_ch[2])
      rdata_next = {16'h0000, chan_value[2]};
    else if (sel_stat)
    begin
      rdata_next[tccv_pkg::STAT_MATCH_LSB +: 3] = match_flag_reg;
      rdata_next[tccv_pkg::STAT_OVCAP_LSB +: 3] = ovcap_flag_reg;
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk)
  begin
    if (rst)
      rdata_reg <= tccv_pkg::RDATA_RST;
    else if (reg_rd)
      rdata_reg <= rdata_next;
    else
      rdata_reg <= tccv_pkg::RDATA_RST;
  end

  assign reg_rdata = rdata_reg;
  assign compare_match = match_evt;
  assign chan_one_match_value = chan_active[0];
  assign chan_two_match_value = chan_active[1];
  assign chan_three_match_value = chan_active[2];
endmodule // tccv_top

// ==== dv/tccv_top_asserts.sv ====
`timescale 1ns/10ps
module tccv_top_asserts (
  input wire logic ref_clk, // Clock
  input wire logic rst, // Reset
  input wire logic [7:0] reg_addr, // Address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write
  input wire logic reg_rd, // Read
  input wire logic [31:0] reg_rdata, // Read data
  input wire logic [15:0] counter_val, // Counter
  input wire logic [2:0] capture_evt, // Captures
  input wire logic update_evt, // Update
  input wire logic [2:0] chan_input_mode, // Modes
  input wire logic [2:0] shadow_en, // Shadows
  input wire logic [2:0] compare_match, // Matches
  input wire logic [15:0] chan_one_match_value // Active value
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic rd1;
  assign rd1 = reg_rd && reg_addr == 8'h38;
  upper_zero_a: assert property (reg_rdata[31:16] == 16'h0000) else $error("upper bits set");
  rd_slot_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000) else $error("data off slot");
  capture_read_a: assert property (capture_evt[0] && chan_input_mode[0] ##1 rd1 && !capture_evt[0]
    |=> reg_rdata[15:0] == $past(counter_val, 2)) else $error("capture lost");
  match_pulse_a: assert property (!chan_input_mode[0] && counter_val == chan_one_match_value
    && counter_val != $past(counter_val) |=> compare_match[0]) else $error("no match");
  shadow_hold_a: assert property (shadow_en[0] && !chan_input_mode[0] && !$past(chan_input_mode[0])
    && !update_evt |=> $stable(chan_one_match_value)) else $error("early load");
  direct_write_a: assert property (reg_wr && reg_addr == 8'h38 && !shadow_en[0] && !chan_input_mode[0]
    && !$past(chan_input_mode[0]) |=> chan_one_match_value == $past(reg_wdata[15:0])) else $error("late");
endmodule // tccv_top_asserts
bind tccv_top tccv_top_asserts tccv_top_asserts_inst (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
  .reg_rdata, .counter_val, .capture_evt, .update_evt, .chan_input_mode, .shadow_en, .compare_match,
  .chan_one_match_value);

// ==== dv/tb_tccv_top.sv ====
`timescale 1ns/10ps
module tb_tccv_top;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [15:0] counter_val = 16'h0;
  logic [2:0] capture_evt = 3'h0;
  logic update_evt = 1'b0;
  logic [2:0] chan_input_mode = 3'h0;
  logic [2:0] shadow_en = 3'h0;
  logic [2:0] compare_match;
  logic [15:0] mval [3];
  logic [7:0] offs [3];
  logic [31:0] seed = 32'h0866;
  logic [31:0] d;
  logic [15:0] v, w;
  int bad_count = 0;
  int num_checks = 0;
  tccv_top tccv_top_inst (.ref_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .counter_val,
    .capture_evt, .update_evt, .chan_input_mode, .shadow_en, .compare_match, .chan_one_match_value(mval[0]),
    .chan_two_match_value(mval[1]), .chan_three_match_value(mval[2]));
  initial forever #5 ref_clk = ~ref_clk;
  function automatic logic [31:0] ex(input logic [15:0] val);
    return {16'h0000, val};
  endfunction
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    num_checks++;
    if (seen !== exp)
    begin
      $display("BAD %s expected %h seen %h", what, exp, seen);
      bad_count++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] dat);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= dat;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask
  // Also ends any capture pulse raised just before
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    capture_evt <= 3'h0;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    bad_count++;
    report_and_stop();
  end
  initial
  begin
    offs = '{tccv_pkg::CH1_OFF, tccv_pkg::CH2_OFF, tccv_pkg::CH3_OFF};
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    rd(8'h44);
    chk("unmapped", 32'h0, d);
    for (int i = 0; i < 3; i++)
    begin
      rd(offs[i]);
      chk("reset", ex(tccv_pkg::VAL_RST), d);
      v = 16'($random(seed));
      w = 16'($random(seed));
      wr(offs[i], {16'hffff, v});
      chk("direct", ex(v), ex(mval[i]));
      rd(offs[i]);
      chk("readback", ex(v), d);
      @(posedge ref_clk);
      shadow_en[i] <= 1'b1;
      wr(offs[i], ex(w));
      chk("shadow hold", ex(v), ex(mval[i]));
      @(posedge ref_clk);
      update_evt <= 1'b1;
      counter_val <= w - 16'h1;
      @(posedge ref_clk);
      update_evt <= 1'b0;
      counter_val <= w;
      #1;
      chk("shadow load", ex(w), ex(mval[i]));
      @(posedge ref_clk);
      #1;
      chk("match", 32'h1, {31'h0, compare_match[i]});
      @(posedge ref_clk);
      chan_input_mode[i] <= 1'b1;
      v = 16'($random(seed));
      counter_val <= v;
      @(posedge ref_clk);
      capture_evt[i] <= 1'b1;
      rd(offs[i]);
      chk("capture", ex(v), d);
      wr(offs[i], ex(~v));
      rd(offs[i]);
      chk("input write", ex(v), d);
      @(posedge ref_clk);
      chan_input_mode[i] <= 1'b0;
      shadow_en[i] <= 1'b0;
    end
    // Sticky status flags: every channel matched once, none overcaptured
    rd(tccv_pkg::STAT_OFF);
    chk("status", 32'h7, d);
    wr(tccv_pkg::STAT_OFF, 32'h77);
    rd(tccv_pkg::STAT_OFF);
    chk("status clear", 32'h0, d);
    // Channel 1 captures on consecutive edges with no read between
    @(posedge ref_clk);
    chan_input_mode[0] <= 1'b1;
    capture_evt[0] <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rd(tccv_pkg::STAT_OFF);
    chk("overcapture", 32'h10, d);
    rd(tccv_pkg::CH1_OFF);
    chk("last capture", ex(counter_val), d);
    report_and_stop();
  end
endmodule // tb_tccv_top
